//--- hdl/fpd_ctrl.v
// Purpose: APB-programmed digital control of a fractional-N synthesizer divider, reference path and VCO calibration.
// Assumes: SYS_CLK 250 MHz, RST_N asynchronous active low, REF_DIV_CLK_IN is a reference-counter output level.
// Notes: Double-buffered settings load in one cycle on a write to the integer low register.
// Overview of operation
// - Reference-mode bit one selects differential input and enables the pair current source.
// - PFD clock equals reference times doubler factor over counter times halver factor.
// - Reference counter divides by 1 through 32 and drives the phase detector.
// - Feedback ratio is whole part plus numerators over fixed 2^25 denominator.
// - Primary numerator accepts 0 to 33,554,431.
// - Auxiliary numerator 0 to 16,383, auxiliary denominator 2 to 16,383, 14 bits.
// - Integer-N mode when both numerators are zero.
// - Numerators, denominator, doubler, halver, counter, pump current are shadowed until commit.
// - Commit with calibration enabled starts selection over four cores of 256 bands.
// - During selection the tuning input ties to the internal reference.
// - Selection is clocked by the reference counter output, then loop resumes.
// - Silicon revision field is readable.
// - Two-bit output current field selects four tail current levels.
// - Tracking filter enable makes filter settings follow output frequency.
//
// The implementer's own choices: the APB register port and the placing of the registers.
`include "fpd_regs.vh"
module fpd_ctrl #(
  parameter [7:0] REVISION = 8'h05 // Arbitrary value.
) (
  input wire SYS_CLK,
  input wire RST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output wire PREADY,
  output wire PSLVERR,
  output reg [31:0] PRDATA,
  input wire REF_DIV_CLK_IN,
  output reg [15:0] INT_WORD,
  output reg [24:0] FRAC_WORD,
  output reg [13:0] AUX_NUM,
  output reg [13:0] AUX_DEN,
  output reg DOUBLER_EN,
  output reg REF_HALVER_BIT,
  output reg [5:0] REF_DIV_RATIO,
  output reg [3:0] CP_CURRENT,
  output reg INTEGER_MODE,
  output reg MODULATOR_OFF,
  output reg REF_DIFF_MODE,
  output reg REF_PAIR_CURRENT_EN,
  output reg TUNE_TO_INTERNAL_REF,
  output reg [1:0] VCO_CORE,
  output reg [7:0] VCO_BAND,
  output reg CAL_BUSY,
  output reg [1:0] OUT_CURRENT,
  output reg TRACK_FILTER_AUTO,
  output reg [2:0] THR_33V,
  output reg [2:0] THR_5V_A,
  output reg [2:0] THR_5V_B
);
  // Band selection states.
  localparam ST_IDLE = 1'b0;
  localparam ST_CAL = 1'b1;
  // Software-written and staged settings.
  reg [15:0] int_q;
  reg autocal_q;
  reg [24:0] pnum_sh_q;
  reg [13:0] anum_sh_q;
  reg [13:0] aden_sh_q;
  reg dbl_sh_q;
  reg half_sh_q;
  reg [4:0] rdiv_sh_q;
  reg [3:0] cp_sh_q;
  reg refmode_q;
  reg track_q;
  reg [1:0] outpwr_q;
  reg modoff_q;
  // Doubler filter code, bias and detector polarity, held for software readback only.
  // They reach no port, so they do not change the divider or the calibration.
  reg [2:0] filt_code_q;
  reg [1:0] filt_bias_q;
  reg pd_pos_q;
  // Reference synchroniser stages.
  reg ref_s1_q;
  reg ref_s2_q;
  reg ref_s3_q;
  // Band selection state.
  reg st_q;
  reg [3:0] step_q;
  reg [4:0] tick_q;
  reg cal_start_q;
  // Bus decode.
  wire wr_en;
  wire [9:0] idx;
  wire commit;
  wire ref_rise;
  // Word index from a byte address.
  function [9:0] word_idx;
    input [11:0] a;
    begin
      word_idx = a[11:2];
    end
  endfunction
  assign idx = word_idx(PADDR);
  assign wr_en = PSEL & PENABLE & PWRITE;
  assign commit = wr_en & (idx == {2'b00, `FPD_IDX_INT_LO});
  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;
  // Software-writable and shadow registers.
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      int_q <= 16'h0000;
      autocal_q <= 1'b0;
      pnum_sh_q <= 25'h0000000;
      anum_sh_q <= 14'h0000;
      aden_sh_q <= `FPD_RST_AUXDEN;
      dbl_sh_q <= 1'b0;
      half_sh_q <= 1'b0;
      rdiv_sh_q <= `FPD_RST_REFDIV;
      cp_sh_q <= 4'h0;
      refmode_q <= 1'b0;
      track_q <= 1'b0;
      outpwr_q <= 2'h0;
      modoff_q <= 1'b0;
      filt_code_q <= `FPD_RST_FILTER;
      filt_bias_q <= `FPD_RST_BIAS;
      pd_pos_q <= `FPD_RST_PDPOL;
      THR_33V <= `FPD_RST_THR;
      THR_5V_A <= `FPD_RST_THR;
      THR_5V_B <= `FPD_RST_THR;
    end else if (wr_en) begin
      case (idx)
        {2'b00, `FPD_IDX_INT_LO}: int_q[7:0] <= PWDATA[7:0];
        {2'b00, `FPD_IDX_INT_HI}: int_q[15:8] <= PWDATA[7:0];
        {2'b00, `FPD_IDX_CAL}: autocal_q <= PWDATA[`FPD_BIT_AUTOCAL];
        {2'b00, `FPD_IDX_PNUM}: pnum_sh_q <= PWDATA[24:0];
        {2'b00, `FPD_IDX_AUX}: begin
          anum_sh_q <= PWDATA[13:0];
          aden_sh_q <= PWDATA[`FPD_AUXDEN_LSB+13:`FPD_AUXDEN_LSB];
        end
        {2'b00, `FPD_IDX_REFDIV}: begin
          rdiv_sh_q <= PWDATA[4:0];
          dbl_sh_q <= PWDATA[`FPD_BIT_DOUBLER];
          half_sh_q <= PWDATA[`FPD_BIT_HALVER];
          cp_sh_q <= PWDATA[`FPD_CP_LSB+3:`FPD_CP_LSB];
        end
        {2'b00, `FPD_IDX_REFMODE}: refmode_q <= PWDATA[`FPD_BIT_REFMODE];
        {2'b00, `FPD_IDX_TRACK}: track_q <= PWDATA[`FPD_BIT_TRACK];
        {2'b00, `FPD_IDX_OUTPWR}: outpwr_q <= PWDATA[1:0];
        {2'b00, `FPD_IDX_MODOFF}: modoff_q <= PWDATA[`FPD_BIT_MODOFF];
        {2'b00, `FPD_IDX_THR33}: THR_33V <= PWDATA[2:0];
        {2'b00, `FPD_IDX_THR5A}: THR_5V_A <= PWDATA[2:0];
        {2'b00, `FPD_IDX_THR5B}: THR_5V_B <= PWDATA[2:0];
        {2'b00, `FPD_IDX_FILTER}: begin
          filt_code_q <= PWDATA[2:0];
          filt_bias_q <= PWDATA[`FPD_BIAS_LSB+1:`FPD_BIAS_LSB];
        end
        {2'b00, `FPD_IDX_PDPOL}: pd_pos_q <= PWDATA[`FPD_BIT_PDPOL];
        default: autocal_q <= autocal_q;
      endcase
    end
  end
  // Active divider settings; the whole set loads at once on commit.
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      INT_WORD <= 16'h0000;
      FRAC_WORD <= 25'h0000000;
      AUX_NUM <= 14'h0000;
      AUX_DEN <= `FPD_RST_AUXDEN;
      DOUBLER_EN <= 1'b0;
      REF_HALVER_BIT <= 1'b0;
      REF_DIV_RATIO <= 6'h01;
      CP_CURRENT <= 4'h0;
      INTEGER_MODE <= 1'b1;
    end else if (commit) begin
      INT_WORD <= {int_q[15:8], PWDATA[7:0]};
      FRAC_WORD <= pnum_sh_q;
      AUX_NUM <= anum_sh_q;
      AUX_DEN <= aden_sh_q;
      DOUBLER_EN <= dbl_sh_q;
      REF_HALVER_BIT <= half_sh_q;
      REF_DIV_RATIO <= {1'b0, rdiv_sh_q} + 6'h01;
      CP_CURRENT <= cp_sh_q;
      INTEGER_MODE <= (pnum_sh_q == 25'h0000000) && (anum_sh_q == 14'h0000);
    end
  end
  // Direct controls that need no buffering.
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REF_DIFF_MODE <= 1'b0;
      REF_PAIR_CURRENT_EN <= 1'b0;
      OUT_CURRENT <= 2'h0;
      TRACK_FILTER_AUTO <= 1'b0;
      MODULATOR_OFF <= 1'b0;
    end else begin
      REF_DIFF_MODE <= refmode_q;
      REF_PAIR_CURRENT_EN <= refmode_q;
      OUT_CURRENT <= outpwr_q;
      TRACK_FILTER_AUTO <= track_q;
      MODULATOR_OFF <= modoff_q & INTEGER_MODE;
    end
  end
  // Synchroniser and edge detect for the reference-counter clock.
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
    end else begin
      ref_s1_q <= REF_DIV_CLK_IN;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
    end
  end
  // Rising edge of the synchronised level; the low reset value matches the idle pin, so no false edge.
  assign ref_rise = ref_s2_q & ~ref_s3_q;
  // Band selection: a fixed walk of two core increments then nine halving band steps, no comparison, one step per sixteen reference ticks.
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= ST_IDLE;
      step_q <= 4'h0;
      tick_q <= 5'h00;
      VCO_CORE <= 2'h0;
      VCO_BAND <= 8'h00;
      CAL_BUSY <= 1'b0;
      TUNE_TO_INTERNAL_REF <= 1'b0;
      cal_start_q <= 1'b0;
    end else begin
      // Start waits one cycle so that the active settings have loaded first.
      cal_start_q <= commit & autocal_q;
      case (st_q)
        ST_IDLE: begin
          if (cal_start_q) begin
            st_q <= ST_CAL;
            step_q <= 4'h0;
            tick_q <= 5'h00;
            VCO_CORE <= 2'h0;
            VCO_BAND <= 8'h00;
            CAL_BUSY <= 1'b1;
            TUNE_TO_INTERNAL_REF <= 1'b1;
          end
        end
        ST_CAL: begin
          if (ref_rise) begin
            if (tick_q == `FPD_STEP_CYCLES - 5'h01) begin
              tick_q <= 5'h00;
              if (step_q < 4'h2)
                VCO_CORE <= VCO_CORE + 2'h1;
              else
                VCO_BAND <= VCO_BAND + (`FPD_BAND_LAST >> (step_q - 4'h2)) + 8'h01;
              if (step_q == `FPD_BAND_STEPS - 4'h1) begin
                st_q <= ST_IDLE;
                CAL_BUSY <= 1'b0;
                TUNE_TO_INTERNAL_REF <= 1'b0;
              end else begin
                step_q <= step_q + 4'h1;
              end
            end else begin
              tick_q <= tick_q + 5'h01;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
  // Read mux.
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL & ~PENABLE & ~PWRITE) begin
      case (idx)
        {2'b00, `FPD_IDX_REV}: PRDATA <= {24'h000000, REVISION};
        {2'b00, `FPD_IDX_INT_LO}: PRDATA <= {24'h000000, int_q[7:0]};
        {2'b00, `FPD_IDX_INT_HI}: PRDATA <= {24'h000000, int_q[15:8]};
        {2'b00, `FPD_IDX_CAL}: PRDATA <= {25'h0000000, autocal_q, 6'h00};
        {2'b00, `FPD_IDX_PNUM}: PRDATA <= {7'h00, pnum_sh_q};
        {2'b00, `FPD_IDX_AUX}: PRDATA <= {2'h0, aden_sh_q, 2'h0, anum_sh_q};
        {2'b00, `FPD_IDX_REFDIV}: PRDATA <= {20'h00000, cp_sh_q, 1'b0, half_sh_q, dbl_sh_q, rdiv_sh_q};
        {2'b00, `FPD_IDX_REFMODE}: PRDATA <= {25'h0000000, refmode_q, 6'h00};
        {2'b00, `FPD_IDX_TRACK}: PRDATA <= {30'h00000000, track_q, 1'b0};
        {2'b00, `FPD_IDX_OUTPWR}: PRDATA <= {30'h00000000, outpwr_q};
        {2'b00, `FPD_IDX_MODOFF}: PRDATA <= {31'h00000000, modoff_q};
        {2'b00, `FPD_IDX_THR33}: PRDATA <= {29'h00000000, THR_33V};
        {2'b00, `FPD_IDX_THR5A}: PRDATA <= {29'h00000000, THR_5V_A};
        {2'b00, `FPD_IDX_THR5B}: PRDATA <= {29'h00000000, THR_5V_B};
        {2'b00, `FPD_IDX_FILTER}: PRDATA <= {26'h0000000, filt_bias_q, 1'b0, filt_code_q};
        {2'b00, `FPD_IDX_PDPOL}: PRDATA <= {31'h00000000, pd_pos_q};
        {2'b00, `FPD_IDX_STATUS}: PRDATA <= {20'h00000, INTEGER_MODE, CAL_BUSY, VCO_CORE, VCO_BAND};
        {2'b00, `FPD_IDX_ACT_FRAC}: PRDATA <= {7'h00, FRAC_WORD};
        {2'b00, `FPD_IDX_ACT_AUX}: PRDATA <= {2'h0, AUX_DEN, 2'h0, AUX_NUM};
        {2'b00, `FPD_IDX_ACT_REF}: PRDATA <= {10'h000, CP_CURRENT, INT_WORD, REF_HALVER_BIT, DOUBLER_EN};
        default: PRDATA <= 32'h00000000;
      endcase
    end
  end
endmodule // fpd_ctrl

//--- hdl/fpd_regs.vh
// Purpose: Register map, field positions and reset values of the fractional PLL divider control.
// Assumes: 32-bit APB data, each register one aligned word.
// Notes: Offsets below are word indices; the byte address is four times the index. 0x44 and 0x45 are local choices.
`ifndef FPD_REGS_VH
`define FPD_REGS_VH
`define FPD_IDX_INT_LO 8'h10
`define FPD_IDX_INT_HI 8'h11
`define FPD_IDX_CAL 8'h12
`define FPD_IDX_PNUM 8'h14
`define FPD_IDX_AUX 8'h17
`define FPD_IDX_REFDIV 8'h1F
`define FPD_IDX_REFMODE 8'h22
`define FPD_IDX_TRACK 8'h23
`define FPD_IDX_OUTPWR 8'h25
`define FPD_IDX_MODOFF 8'h2B
`define FPD_IDX_THR33 8'h2D
`define FPD_IDX_THR5A 8'h2E
`define FPD_IDX_THR5B 8'h2F
`define FPD_IDX_REV 8'h06
`define FPD_IDX_STATUS 8'h40
`define FPD_IDX_ACT_FRAC 8'h41
`define FPD_IDX_ACT_AUX 8'h42
`define FPD_IDX_ACT_REF 8'h43
`define FPD_IDX_FILTER 8'h44
`define FPD_IDX_PDPOL 8'h45
`define FPD_BIAS_LSB 4
`define FPD_BIT_PDPOL 0
`define FPD_RST_FILTER 3'h0
`define FPD_RST_BIAS 2'h0
`define FPD_RST_PDPOL 1'h0
`define FPD_BIT_AUTOCAL 6
`define FPD_BIT_REFMODE 6
`define FPD_BIT_TRACK 1
`define FPD_BIT_MODOFF 0
`define FPD_BIT_DOUBLER 5
`define FPD_BIT_HALVER 6
`define FPD_CP_LSB 8
`define FPD_AUXDEN_LSB 16
`define FPD_RST_AUXDEN 14'h0002
`define FPD_RST_REFDIV 5'h00
`define FPD_RST_THR 3'h0
`define FPD_BAND_STEPS 4'hB
`define FPD_STEP_CYCLES 5'h10
`define FPD_BAND_LAST 8'hFF
`endif

//--- verif/fpd_ctrl_asserts.sv
// Purpose: Port checker for the fractional PLL divider control.
// Assumes: Bound to fpd_ctrl and sees only its ports.
// Notes: A commit is a completed write to byte address 0x040.
module fpd_ctrl_asserts (
  input wire SYS_CLK,
  input wire RST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [24:0] FRAC_WORD,
  input wire [13:0] AUX_NUM,
  input wire [13:0] AUX_DEN,
  input wire DOUBLER_EN,
  input wire REF_HALVER_BIT,
  input wire [5:0] REF_DIV_RATIO,
  input wire [3:0] CP_CURRENT,
  input wire INTEGER_MODE,
  input wire MODULATOR_OFF,
  input wire REF_DIFF_MODE,
  input wire REF_PAIR_CURRENT_EN,
  input wire TUNE_TO_INTERNAL_REF,
  input wire CAL_BUSY
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shadowed outputs as one vector, and the decoded commit write.
  wire [64:0] shadow = {FRAC_WORD, AUX_NUM, AUX_DEN, DOUBLER_EN, REF_HALVER_BIT, REF_DIV_RATIO, CP_CURRENT};
  wire commit = PSEL && PENABLE && PWRITE && (PADDR == 12'h040);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // The pair current source follows the input mode bit.
  a_pair_mode: assert property (REF_PAIR_CURRENT_EN == REF_DIFF_MODE)
    else $error("pair current differs from input mode.");
  a_ratio_range: assert property (REF_DIV_RATIO >= 6'h01 && REF_DIV_RATIO <= 6'h20)
    else $error("reference ratio out of range.");
  a_int_mode: assert property (INTEGER_MODE == (FRAC_WORD == 25'h0 && AUX_NUM == 14'h0))
    else $error("integer mode disagrees with numerators.");
  a_modoff_int: assert property (MODULATOR_OFF |-> $past(INTEGER_MODE))
    else $error("modulator off outside integer mode.");
  // Shadowed values only move after a commit, and all at once.
  a_shadow_cause: assert property ($changed(shadow) |-> $past(commit) || $past(commit, 2) || $past(commit, 3))
    else $error("shadowed output changed without commit.");
  a_shadow_once: assert property ($changed(shadow) |=> $stable(shadow))
    else $error("shadowed outputs changed over two cycles.");
  a_tune_busy: assert property (TUNE_TO_INTERNAL_REF == CAL_BUSY)
    else $error("tuning switch differs from band selection.");
  a_cal_bound: assert property ($rose(CAL_BUSY) |-> ##[1:1000] !CAL_BUSY)
    else $error("band selection did not finish.");
  a_cal_start: assert property ($rose(CAL_BUSY) |-> $past(commit, 2) || $past(commit, 3) || $past(commit, 4))
    else $error("band selection started without commit.");
endmodule // fpd_ctrl_asserts

bind fpd_ctrl fpd_ctrl_asserts i_fpd_ctrl_asserts (.SYS_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .FRAC_WORD, .AUX_NUM, .AUX_DEN, .DOUBLER_EN, .REF_HALVER_BIT, .REF_DIV_RATIO, .CP_CURRENT, .INTEGER_MODE,
  .MODULATOR_OFF, .REF_DIFF_MODE, .REF_PAIR_CURRENT_EN, .TUNE_TO_INTERNAL_REF, .CAL_BUSY);

//--- verif/tb_fpd_ctrl.sv
// Purpose: Self-checking bench for the fractional PLL divider control.
// Assumes: APB master tasks, reference counter output toggled every 2 cycles.
// Notes: Registers are addressed by word index, byte address is four times it.
`include "fpd_regs.vh"
module tb_fpd_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [7:0] REV = 8'h3C; // Arbitrary value.
  logic SYS_CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, REF_DIV_CLK_IN = 0, ref_run = 1;
  logic [1:0] rc = 2'h0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, rdat;
  wire PREADY, PSLVERR, DOUBLER_EN, REF_HALVER_BIT, INTEGER_MODE, MODULATOR_OFF, REF_DIFF_MODE;
  wire REF_PAIR_CURRENT_EN, TUNE_TO_INTERNAL_REF, CAL_BUSY, TRACK_FILTER_AUTO;
  wire [31:0] PRDATA;
  wire [15:0] INT_WORD;
  wire [24:0] FRAC_WORD;
  wire [13:0] AUX_NUM, AUX_DEN;
  wire [5:0] REF_DIV_RATIO;
  wire [3:0] CP_CURRENT;
  wire [1:0] VCO_CORE, OUT_CURRENT;
  wire [7:0] VCO_BAND;
  wire [2:0] THR_33V, THR_5V_A, THR_5V_B;
  int fail_count = 0, samples_checked = 0, n;
  fpd_ctrl #(.REVISION(REV)) i_fpd_ctrl (.SYS_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY,
    .PSLVERR, .PRDATA, .REF_DIV_CLK_IN, .INT_WORD, .FRAC_WORD, .AUX_NUM, .AUX_DEN, .DOUBLER_EN, .REF_HALVER_BIT,
    .REF_DIV_RATIO, .CP_CURRENT, .INTEGER_MODE, .MODULATOR_OFF, .REF_DIFF_MODE, .REF_PAIR_CURRENT_EN,
    .TUNE_TO_INTERNAL_REF, .VCO_CORE, .VCO_BAND, .CAL_BUSY, .OUT_CURRENT, .TRACK_FILTER_AUTO, .THR_33V,
    .THR_5V_A, .THR_5V_B);
  // System clock and a reference counter output that can be paused.
  always #2 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) begin
    rc <= rc + 2'h1;
    if (ref_run && rc[0]) REF_DIV_CLK_IN <= !REF_DIV_CLK_IN;
  end
  // One APB transfer; read data is kept in rdat.
  task automatic xfer(input logic wr, input logic [9:0] w, input logic [31:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= {w, 2'b00};
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    @(posedge SYS_CLK);
    while (PREADY !== 1'b1) @(posedge SYS_CLK);
    rdat = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [9:0] w, input logic [31:0] e, input string nm);
    xfer(1'b0, w, 32'h0);
    chk(nm, e, rdat);
  endtask
  // Lets registered outputs land before they are looked at.
  task automatic settle;
    repeat (3) @(posedge SYS_CLK);
    #1;
  endtask
  task automatic results;
    if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    #100000;
    fail_count++;
    results;
  end
  // Main sequence.
  initial begin
    repeat (5) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    chk("reset", {6'h01, 14'h0002, 1'b1}, {REF_DIV_RATIO, AUX_DEN, INTEGER_MODE});
    rd(10'h006, {24'h0, REV}, "revision");
    rd(10'h03F, 32'h0, "unmapped");
    chk("slverr", 32'h0, PSLVERR);
    for (int m = 1; m >= 0; m--) begin
      xfer(1'b1, 10'h022, 32'(m) << 6);
      settle;
      chk("ref_mode", {m[0], m[0]}, {REF_DIFF_MODE, REF_PAIR_CURRENT_EN});
    end
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, 10'h025, k);
      settle;
      chk("out_current", k, OUT_CURRENT);
    end
    xfer(1'b1, 10'h023, 32'h2);
    xfer(1'b1, 10'h02D, 32'h1);
    xfer(1'b1, 10'h02E, 32'h2);
    xfer(1'b1, 10'h02F, 32'h4);
    settle;
    chk("track", 1, TRACK_FILTER_AUTO);
    chk("thresholds", 32'h054, {THR_33V, THR_5V_A, THR_5V_B});
    // Staged values stay hidden until the integer low word is written.
    xfer(1'b1, 10'h014, 32'h1FFFFFF);
    xfer(1'b1, 10'h017, {2'b0, 14'h3FFF, 2'b0, 14'h3FFF});
    xfer(1'b1, 10'h01F, 32'h0A7F);
    xfer(1'b1, 10'h011, 32'h0);
    settle;
    chk("staged", {25'h0, 6'h01}, {FRAC_WORD, REF_DIV_RATIO});
    xfer(1'b1, 10'h010, 32'h4B);
    settle;
    chk("frac", 32'h1FFFFFF, FRAC_WORD);
    chk("aux", {4'h0, 14'h3FFF, 14'h3FFF}, {AUX_NUM, AUX_DEN});
    chk("ref_path", {6'h20, 4'hA, 2'b11}, {REF_DIV_RATIO, CP_CURRENT, DOUBLER_EN, REF_HALVER_BIT});
    chk("int", {1'b0, 16'h004B}, {INTEGER_MODE, INT_WORD});
    rd(10'h043, {10'h0, 4'hA, 16'h004B, 2'b11}, "act_ref");
    rd(10'h041, 32'h01FFFFFF, "act_frac");
    rd(10'h042, {2'h0, 14'h3FFF, 2'h0, 14'h3FFF}, "act_aux");
    // Zero numerators give integer mode with the modulators off.
    xfer(1'b1, 10'h014, 32'h0);
    xfer(1'b1, 10'h017, 32'h00020000);
    xfer(1'b1, 10'h01F, 32'h0);
    xfer(1'b1, 10'h02B, 32'h1);
    xfer(1'b1, 10'h010, 32'h14);
    settle;
    chk("int_mode", {2'b11, 6'h01}, {INTEGER_MODE, MODULATOR_OFF, REF_DIV_RATIO});
    // Band selection holds while the reference counter output stands still.
    xfer(1'b1, 10'h012, 32'h40);
    xfer(1'b1, 10'h010, 32'h14);
    for (n = 0; n < 20 && CAL_BUSY !== 1'b1; n++) @(posedge SYS_CLK);
    chk("tune", 1, TUNE_TO_INTERNAL_REF);
    ref_run <= 1'b0;
    repeat (150) @(posedge SYS_CLK);
    chk("held", 1, CAL_BUSY);
    ref_run <= 1'b1;
    for (n = 0; n < 1000 && CAL_BUSY !== 1'b0; n++) @(posedge SYS_CLK);
    chk("cal_done", 0, {CAL_BUSY, TUNE_TO_INTERNAL_REF});
    chk("band", {2'h2, `FPD_BAND_LAST}, {VCO_CORE, VCO_BAND});
    rd(10'h040, {20'h0, 2'b10, 2'h2, `FPD_BAND_LAST}, "status");
    // Doubler filter code 7 with bias 3 and positive detector polarity read back as written.
    xfer(1'b1, {2'b00, `FPD_IDX_FILTER}, {26'h0, 2'h3, 1'b0, 3'h7});
    xfer(1'b1, {2'b00, `FPD_IDX_PDPOL}, 32'h1);
    rd({2'b00, `FPD_IDX_FILTER}, {26'h0, 2'h3, 1'b0, 3'h7}, "filter");
    rd({2'b00, `FPD_IDX_PDPOL}, 32'h1, "polarity");
    results;
  end
endmodule // tb_fpd_ctrl
